//--- reset_and_power_control.sv
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "rst_pwr_regs.svh"

module reset_and_power_control
(
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  hsel,
    input  wire logic [11:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire logic                  power_low,
    input  wire logic                  ext_reset_n,
    input  wire logic                  external_reset_disable_fuse,
    input  wire logic                  watchdog_expired,
    input  wire logic                  watchdog_reset_mode,
    input  wire logic                  brownout_low,
    input  wire logic                  brownout_fuse_enabled,
    input  wire rst_pwr_pkg::count_t   startup_delay_cycles,
    input  wire logic                  sleep_exec,
    input  wire logic                  comparator_bandgap_select,
    input  wire logic                  converter_enable,
    input  wire logic                  timer_two_async_select,
    output logic                       port_reset,
    output logic                       internal_reset,
    output logic                       brownout_sleep_off,
    output logic                       brownout_detector_on,
    output logic                       gate_two_wire_clock,
    output logic                       gate_timer_two_clock,
    output logic                       gate_timer_zero_clock,
    output logic                       gate_timer_one_clock,
    output logic                       gate_serial_periph_clock,
    output logic                       gate_uart_clock,
    output logic                       gate_converter,
    output logic                       comparator_mux_block,
    output logic                       reference_enable
);
    import rst_pwr_pkg::*;

    // ------------------------------------------------------------------
    // Reset sources
    // ------------------------------------------------------------------
    // Watchdog expiry is shaped into a single-cycle pulse so a long
    // expiry level cannot hold reset beyond one cycle.
    logic wd_seen_q;
    logic wd_pulse_q;
    wire  wd_rise = watchdog_expired & watchdog_reset_mode & ~wd_seen_q;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            wd_seen_q <= 1'b0;
        else
            wd_seen_q <= watchdog_expired & watchdog_reset_mode;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            wd_pulse_q <= 1'b0;
        else
            wd_pulse_q <= wd_rise;
    end

    wire ext_src  = ~ext_reset_n & ~external_reset_disable_fuse;
    wire bod_src  = brownout_low & brownout_fuse_enabled;
    // Every source but the watchdog is combinational so it acts at
    // once even when the clock is stopped.
    wire any_src  = power_low | ext_src | bod_src | wd_pulse_q;
    wire async_src = sys_rst | power_low | ext_src | bod_src;

    // ------------------------------------------------------------------
    // Delay counter
    // ------------------------------------------------------------------
    count_t dly_q;
    logic   stretch_q;

    always_ff @(posedge clk or posedge async_src)
    begin
        if (async_src)
            dly_q <= 16'h0000;
        else if (wd_pulse_q)
            dly_q <= 16'h0000;
        else if (dly_q != startup_delay_cycles)
            dly_q <= dly_q + 16'h0001;
    end

    always_ff @(posedge clk or posedge async_src)
    begin
        if (async_src)
            stretch_q <= 1'b1;
        else
            stretch_q <= wd_pulse_q | (dly_q != startup_delay_cycles);
    end

    assign port_reset     = async_src | wd_pulse_q;
    assign internal_reset = port_reset | stretch_q;

    // Register state of this block uses the stretched reset as well.
    wire reg_rst = internal_reset;

    // ------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------
    logic        ph_wr_q;
    logic [11:0] ph_addr_q;
    wire  take    = hsel & htrans[1] & hready;
    wire  wr_mcu  = ph_wr_q & (ph_addr_q == `ADDR_MCU_CONTROL);
    wire  wr_gate = ph_wr_q & (ph_addr_q == `ADDR_PERIPH_GATING);
    wire  wd_off  = hwdata[`BIT_SLEEP_OFF];
    wire  wd_unl  = hwdata[`BIT_SLEEP_UNLOCK];

    always_ff @(posedge clk or posedge reg_rst)
    begin
        if (reg_rst)
            ph_wr_q <= 1'b0;
        else
            ph_wr_q <= take & hwrite;
    end

    always_ff @(posedge clk or posedge reg_rst)
    begin
        if (reg_rst)
            ph_addr_q <= 12'h000;
        else if (take)
            ph_addr_q <= haddr;
    end

    // ------------------------------------------------------------------
    // Brown-out sleep-off timed sequence
    // ------------------------------------------------------------------
    sleep_off_e so_q;
    sleep_off_e so_d;
    logic [2:0] win_q;
    logic [1:0] so_cnt_q;
    logic       unlock_q;
    wire  unlock_wr = wr_mcu & wd_off & wd_unl;
    wire  arm_wr    = wr_mcu & wd_off & ~wd_unl & (win_q != 3'd0);
    wire  so_done   = (so_cnt_q == 2'd1);

    always_ff @(posedge clk or posedge reg_rst)
    begin
        if (reg_rst)
            win_q <= 3'd0;
        else if (unlock_wr)
            win_q <= `UNLOCK_WINDOW_CYCLES;
        else if (arm_wr)
            win_q <= 3'd0;
        else if (win_q != 3'd0)
            win_q <= win_q - 3'd1;
    end

    always_ff @(posedge clk or posedge reg_rst)
    begin
        if (reg_rst)
            unlock_q <= 1'b0;
        else
            unlock_q <= (win_q != 3'd0) | unlock_wr;
    end

    always_comb
    begin
        so_d = so_q;
        unique case (so_q)
            SO_IDLE:   if (arm_wr) so_d = SO_ARMING;
            SO_ARMING: if (so_done) so_d = SO_ACTIVE;
            SO_ACTIVE: if (so_done) so_d = SO_IDLE;
            default:   so_d = SO_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge reg_rst)
    begin
        if (reg_rst)
            so_q <= SO_IDLE;
        else
            so_q <= so_d;
    end

    always_ff @(posedge clk or posedge reg_rst)
    begin
        if (reg_rst)
            so_cnt_q <= 2'd0;
        else if (so_q == SO_IDLE && arm_wr)
            so_cnt_q <= `SLEEP_OFF_DELAY_CYCLES;
        else if (so_q == SO_ARMING && so_done)
            so_cnt_q <= `SLEEP_OFF_LIFE_CYCLES;
        else if (so_cnt_q != 2'd0)
            so_cnt_q <= so_cnt_q - 2'd1;
    end

    // The stored bit shows set from the arming write; the active window
    // is what gates the detector.
    wire so_set    = (so_q != SO_IDLE);
    wire so_active = (so_q == SO_ACTIVE);
    logic bod_sleeping_q;

    always_ff @(posedge clk or posedge reg_rst)
    begin
        if (reg_rst)
            bod_sleeping_q <= 1'b0;
        else if (sleep_exec)
            bod_sleeping_q <= so_active;
        else if (~sleep_exec & bod_sleeping_q & ~so_active)
            bod_sleeping_q <= 1'b0;
    end

    assign brownout_sleep_off   = so_active;
    assign brownout_detector_on = brownout_fuse_enabled & ~bod_sleeping_q;

    // ------------------------------------------------------------------
    // Peripheral clock gating
    // ------------------------------------------------------------------
    byte_t gate_q;

    always_ff @(posedge clk or posedge reg_rst)
    begin
        if (reg_rst)
            gate_q <= `GATING_RESET;
        else if (wr_gate)
            gate_q <= hwdata[7:0] & `GATING_WRITE_MASK;
    end

    // A gated block keeps its state because its clock simply stops.
    assign gate_two_wire_clock      = gate_q[`BIT_GATE_TWO_WIRE];
    assign gate_timer_two_clock     = gate_q[`BIT_GATE_TIMER_TWO]
                                      & ~timer_two_async_select;
    assign gate_timer_zero_clock    = gate_q[`BIT_GATE_TIMER_ZERO];
    assign gate_timer_one_clock     = gate_q[`BIT_GATE_TIMER_ONE];
    assign gate_serial_periph_clock = gate_q[`BIT_GATE_SERIAL_PERIPH];
    assign gate_uart_clock          = gate_q[`BIT_GATE_UART];
    assign gate_converter           = gate_q[`BIT_GATE_CONVERTER];
    assign comparator_mux_block     = gate_q[`BIT_GATE_CONVERTER];

    assign reference_enable = brownout_fuse_enabled
                              | comparator_bandgap_select
                              | converter_enable;

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    wire rd_mcu  = take & ~hwrite & (haddr == `ADDR_MCU_CONTROL);
    wire rd_gate = take & ~hwrite & (haddr == `ADDR_PERIPH_GATING);
    wire rd_stat = take & ~hwrite & (haddr == `ADDR_REF_STATUS);
    wire [31:0] mcu_word  = {25'h0, so_set, unlock_q, 5'h00};
    wire [31:0] gate_word = {24'h0, gate_q};
    wire [31:0] stat_word = {29'h0, bod_sleeping_q, brownout_detector_on,
                             reference_enable};
    wire [31:0] rd_word   = rd_mcu  ? mcu_word  :
                            rd_gate ? gate_word :
                            rd_stat ? stat_word : 32'h0000_0000;

    always_ff @(posedge clk or posedge reg_rst)
    begin
        if (reg_rst)
            hrdata <= 32'h0000_0000;
        else if (take)
            hrdata <= rd_word;
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_wd_pulse_one: assert property (@(posedge clk) disable iff (sys_rst)
        wd_pulse_q |=> ~wd_pulse_q)
        else $error("watchdog reset pulse longer than one cycle");

    chk_arm_active: assert property (@(posedge clk) disable iff (reg_rst)
        (so_q == SO_IDLE && arm_wr) |=> ~so_active[*3]
        ##1 so_active)
        else $error("sleep-off not active three cycles after set");

    chk_auto_clear: assert property (@(posedge clk) disable iff (reg_rst)
        $rose(so_active) |-> so_active[*3] ##1 ~so_active)
        else $error("sleep-off did not clear after three cycles");

    chk_no_unlock_arm: assert property (@(posedge clk) disable iff (reg_rst)
        (wr_mcu && win_q == 3'd0 && so_q == SO_IDLE) |=> so_q == SO_IDLE)
        else $error("sleep-off set without unlock");

    chk_bod_sleep: assert property (@(posedge clk) disable iff (reg_rst)
        (sleep_exec && !so_active) |=> brownout_detector_on
        == brownout_fuse_enabled)
        else $error("detector off without sleep-off");

    chk_reserved_zero: assert property (@(posedge clk) disable iff (reg_rst)
        gate_q[`BIT_GATE_RESERVED] == 1'b0)
        else $error("reserved gating bit set");

    chk_reset_or: assert property (@(posedge clk)
        (power_low || ext_src || bod_src) |-> internal_reset)
        else $error("reset source did not assert reset");

    chk_timer_two: assert property (@(posedge clk) disable iff (reg_rst)
        timer_two_async_select |-> !gate_timer_two_clock)
        else $error("timer two gated in asynchronous mode");

    chk_stretch: assert property (@(posedge clk) disable iff (port_reset)
        $fell(wd_pulse_q) && startup_delay_cycles > 16'h0001
        |-> internal_reset[*2])
        else $error("reset not stretched after release");

endmodule

//--- rst_pwr_regs.svh
`ifndef RST_PWR_REGS_SVH
`define RST_PWR_REGS_SVH

// ------------------------------------------------------------------
// Register map (byte addresses on the AHB-Lite bus)
// ------------------------------------------------------------------
`define ADDR_MCU_CONTROL        12'h000
`define ADDR_PERIPH_GATING      12'h004
`define ADDR_REF_STATUS         12'h008

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define BIT_SLEEP_OFF           6
`define BIT_SLEEP_UNLOCK        5
`define BIT_GATE_TWO_WIRE       7
`define BIT_GATE_TIMER_TWO      6
`define BIT_GATE_TIMER_ZERO     5
`define BIT_GATE_RESERVED       4
`define BIT_GATE_TIMER_ONE      3
`define BIT_GATE_SERIAL_PERIPH  2
`define BIT_GATE_UART           1
`define BIT_GATE_CONVERTER      0

// ------------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------------
`define GATING_RESET            8'h00
`define GATING_WRITE_MASK       8'hEF
`define UNLOCK_WINDOW_CYCLES    3'd4
`define SLEEP_OFF_DELAY_CYCLES  2'd3
`define SLEEP_OFF_LIFE_CYCLES   2'd3

`endif

//--- rst_pwr_pkg.sv
package rst_pwr_pkg;

    typedef logic [7:0]  byte_t;
    typedef logic [15:0] count_t;

    typedef enum logic [2:0]
    {
        SO_IDLE   = 3'b001,
        SO_ARMING = 3'b010,
        SO_ACTIVE = 3'b100
    } sleep_off_e;

endpackage

//--- core_periph_model.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Stand-in for timer zero on the far side of the clock gate
// ----------------------------------------------------------------
module core_periph_model
(
    input  wire logic       clk,
    input  wire logic       internal_reset,
    input  wire logic       gate_timer_zero_clock,
    output logic [7:0]      timer_count
);
    // The count only moves on ungated edges, so a gate that leaks even
    // one edge shows up as a shifted count in the bench.
    always_ff @(posedge clk or posedge internal_reset)
    begin
        if (internal_reset)
            timer_count <= 8'h00;
        else if (!gate_timer_zero_clock)
            timer_count <= timer_count + 8'h01;
    end
endmodule

//--- tb_top.sv
`timescale 1ns/10ps
`include "rst_pwr_regs.svh"

// ----------------------------------------------------------------
// Self-checking bench for the reset and power control block
// ----------------------------------------------------------------
module tb_top;
    import rst_pwr_pkg::*;
    localparam int DLY = 8;
    logic        clk, sys_rst, hsel, hwrite, hreadyout, hresp;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, q, seed;
    logic        power_low, ext_reset_n, rst_dis, wd_exp, wd_mode;
    logic        bo_low, bo_fuse, sleep_exec, bandgap, conv_en, async2;
    logic        port_reset, internal_reset, sleep_off, det_on;
    logic [7:0]  g, s, e, timer_count, t0;
    logic        mux_block, ref_en;
    logic [31:0] model[$];
    int          n_errors, n_checks, n, c;

    reset_and_power_control dut
    (
        .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .power_low(power_low),
        .ext_reset_n(ext_reset_n),
        .external_reset_disable_fuse(rst_dis),
        .watchdog_expired(wd_exp), .watchdog_reset_mode(wd_mode),
        .brownout_low(bo_low), .brownout_fuse_enabled(bo_fuse),
        .startup_delay_cycles(16'(DLY)), .sleep_exec(sleep_exec),
        .comparator_bandgap_select(bandgap),
        .converter_enable(conv_en), .timer_two_async_select(async2),
        .port_reset(port_reset), .internal_reset(internal_reset),
        .brownout_sleep_off(sleep_off), .brownout_detector_on(det_on),
        .gate_two_wire_clock(g[7]), .gate_timer_two_clock(g[6]),
        .gate_timer_zero_clock(g[5]), .gate_timer_one_clock(g[3]),
        .gate_serial_periph_clock(g[2]), .gate_uart_clock(g[1]),
        .gate_converter(g[0]), .comparator_mux_block(mux_block),
        .reference_enable(ref_en)
    );

    core_periph_model partner
    (
        .clk(clk), .internal_reset(internal_reset),
        .gate_timer_zero_clock(g[5]), .timer_count(timer_count)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // Called in the time step of a rising edge; returns in one as well.
    task automatic bus(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'b010;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        check(hresp, 0, "response");
    endtask

    task automatic wait_run(output int cnt);
        cnt = 0;
        while (internal_reset !== 1'b0 && cnt < 100)
        begin
            @(posedge clk);
            cnt++;
        end
    endtask

    initial
    begin : watchdog
        repeat (20000) @(posedge clk);
        n_errors++;
        $display("BAD %0t run did not finish", $time);
        print_verdict();
    end

    initial
    begin
        {hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
        {power_low, rst_dis, wd_exp, wd_mode, bo_low} = '0;
        {sleep_exec, bandgap, async2} = '0;
        // The converter stays disabled whenever its gate is set.
        conv_en = 1'b0;
        ext_reset_n = 1'b1;
        bo_fuse = 1'b1;
        sys_rst = 1'b1;
        seed = 32'h9E78;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        wait_run(n);
        check(n >= DLY && n <= DLY + 3, 1, "stretch");
        bus(0, `ADDR_PERIPH_GATING, 0, q);
        check(q, `GATING_RESET, "gating reset");
        $display("test reset done");

        for (int i = 0; i < 6; i++)
        begin
            e = (i == 0) ? 8'hFF : 8'($random(seed));
            async2 <= i[0];
            model.push_back(32'(e & `GATING_WRITE_MASK));
            bus(1, `ADDR_PERIPH_GATING, 32'(e), q);
            bus(0, `ADDR_PERIPH_GATING, 0, q);
            e = 8'(model.pop_front());
            check(q, e, "gating readback");
            check({g[7:5], g[3:0], mux_block},
                  {e[7], e[6] & ~i[0], e[5], e[3:0], e[0]}, "gates");
        end
        bus(1, 12'h00C, 32'hFF, q);
        bus(0, 12'h00C, 0, q);
        check(q, 0, "unmapped");
        bus(1, `ADDR_PERIPH_GATING, 32'h20, q);
        #1 t0 = timer_count;
        repeat (4) @(posedge clk);
        #1 check(timer_count, t0, "frozen timer");
        @(posedge clk);
        bus(1, `ADDR_PERIPH_GATING, 0, q);
        #1 t0 = timer_count;
        repeat (3) @(posedge clk);
        #1 check(timer_count, t0 + 8'h03, "resumed timer");
        @(posedge clk);
        $display("test gating done");

        bus(1, `ADDR_MCU_CONTROL, 32'h40, q);
        bus(1, `ADDR_MCU_CONTROL, 32'h60, q);
        bus(1, `ADDR_MCU_CONTROL, 32'h40, q);
        for (int i = 1; i <= 8; i++)
        begin
            @(posedge clk);
            sleep_exec <= (i == 3);
            #1 s[i-1] = sleep_off;
            if (i == 5)
                check(det_on, 0, "detector off in sleep");
        end
        check(s, 8'b0001_1100, "sleep-off timing");
        @(posedge clk);
        sleep_exec <= 1'b1;
        @(posedge clk);
        sleep_exec <= 1'b0;
        @(posedge clk);
        #1 check(det_on, 1, "detector back on");
        $display("test sleep-off done");

        for (int k = 0; k < 5; k++)
        begin
            @(posedge clk);
            power_low <= (k == 0);
            ext_reset_n <= !(k == 1 || k == 2);
            rst_dis <= (k == 2);
            bo_low <= (k >= 3);
            bo_fuse <= (k != 4);
            #1 check(port_reset, k != 2 && k != 4, "source");
            repeat (2) @(posedge clk);
            {power_low, bo_low} <= 2'b00;
            ext_reset_n <= 1'b1;
            wait_run(n);
            check(n >= DLY && n <= DLY + 3, k != 2 && k != 4, "release");
        end
        for (int m = 0; m < 2; m++)
        begin
            @(posedge clk);
            wd_mode <= m[0];
            wd_exp <= 1'b1;
            c = 0;
            repeat (4)
            begin
                @(posedge clk);
                #1 c += int'(port_reset);
            end
            check(c, m, "watchdog pulse");
            @(posedge clk);
            wd_exp <= 1'b0;
            wait_run(n);
            // Five edges have passed since expiry when the wait starts.
            n = n + 5;
            check(n >= DLY + 2 && n <= DLY + 5, m, "watchdog stretch");
        end
        $display("test reset sources done");

        // No comparator or converter result is used here.
        for (int r = 0; r < 8; r++)
        begin
            {bo_fuse, bandgap, conv_en} <= 3'(r);
            bus(0, `ADDR_REF_STATUS, 0, q);
            check(ref_en, r != 0, "reference");
            check(q[1:0], {r[2], r != 0}, "status");
        end
        $display("test reference done");
        print_verdict();
    end
endmodule
